// >>> rtl/vih_pkg.sv
package vih_pkg;

  // Maskable request sources
  localparam int NSRC        = 16;
  localparam int SRC_TIMER0  = 0;
  localparam int SRC_TIMER1  = 1;
  localparam int SRC_UART    = 2;
  localparam int SRC_SYNC_SER = 3;
  localparam int SRC_ADC     = 4;
  localparam int SRC_EXT0    = 5;
  localparam int SRC_EXT1    = 6;
  localparam int SRC_XEVT    = 7;
  localparam int SRC_GTA     = 8;
  localparam int SRC_GTB     = 9;
  localparam int SRC_MULDIV  = 10;
  localparam int SRC_EXT2    = 11;
  localparam int SRC_LIN     = 12;
  localparam int SRC_CC0     = 13;
  localparam int SRC_CC1     = 14;
  localparam int SRC_CC2     = 15;

  // Vectors and levels
  localparam int NVEC        = 14;
  localparam int VEC_W       = 4;
  localparam int LVL_W       = 2;
  localparam int NLVL        = 4;
  localparam int NPERIPH_VEC = 11;
  localparam int NSHARED_VEC = 6;
  localparam logic [VEC_W-1:0] VEC_SHARED_EXT2 = 4'h9;

  // Source to vector routing
  localparam logic [VEC_W-1:0] SRC_VEC [NSRC] = '{
    4'h1, 4'h3, 4'h4, 4'h7, 4'h6, 4'h0, 4'h2, 4'h5,
    4'h8, 4'h9, 4'h9, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd
  };

  // Non-maskable event sources
  localparam int NNMI          = 11;
  localparam int NMI_WDT_WARN  = 0;
  localparam int NMI_LPWDT_OVF = 1;
  localparam int NMI_PLL_UNLK  = 2;
  localparam int NMI_OSC_LOW   = 3;
  localparam int NMI_FLASH_DONE = 4;
  localparam int NMI_FLASH_MAP = 5;
  localparam int NMI_ECC_FLASH = 6;
  localparam int NMI_ECC_EXTENDED_RAM  = 7;
  localparam int NMI_ECC_INTERNAL_RAM  = 8;
  localparam int NMI_DBG_RAM   = 9;
  localparam int NMI_SUPPLY    = 10;

  // Per-vector configuration
  typedef struct packed {
    logic             en;
    logic [LVL_W-1:0] prio;
  } vih_vcfg_t;

  // Request presented to the core
  typedef struct packed {
    logic             req;
    logic [VEC_W-1:0] vec;
    logic [LVL_W-1:0] lvl;
  } vih_irq_t;

endpackage : vih_pkg

// >>> rtl/vih_hub.sv
// Functional notes
// - Fourteen vectors, each given one of four priority levels.
// - Core sees fifteen sources over four levels, counting the NMI.
// - Timers 0/1, UART, serial channel, ADC own one vector each.
// - General timers, mul/div, LIN, capture/compare share six vectors.
// - External inputs 0 and 1 each have a dedicated vector.
// - External input 2 shares a vector with timer B and mul/div.
// - One vector serves the extended event group.
// - One NMI above all levels, raised by any of its sources.
// - Watchdog early warning feeds the NMI.
// - Low-power clock watchdog overflow feeds the NMI.
// - PLL lock loss and low oscillator frequency feed the NMI.
// - Flash operation done and flash map error feed the NMI.
// - Uncorrectable ECC in flash, extended or internal RAM feeds NMI.
// - Debug-support internal RAM event feeds the NMI.
// - Supply pre-warning feeds the NMI.
`timescale 1ns/100ps
`default_nettype none

module vih_hub
  import vih_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic [NSRC-1:0]       src_req,
  input  wire logic [NSRC-1:0]       src_clr,
  input  wire logic [NNMI-1:0]       nmi_evt,
  input  wire logic [NNMI-1:0]       nmi_clr,
  input  wire vih_vcfg_t [NVEC-1:0]  vec_cfg,
  output var  logic [NSRC-1:0]       src_pend_r,
  output var  logic [NNMI-1:0]       nmi_pend_r,
  output var  logic [NVEC-1:0]       vec_pend_r,
  output var  logic                  nmi_req_r,
  output var  vih_irq_t              irq_r
);

  logic [NSRC-1:0] src_pend_nxt;
  logic [NNMI-1:0] nmi_pend_nxt;
  logic [NVEC-1:0] vec_pend_nxt;
  logic            nmi_req_nxt;
  vih_irq_t        irq_nxt;

  // Pending flags; a new event beats a clear in the same cycle
  always_comb begin
    src_pend_nxt = (src_pend_r & ~src_clr) | src_req;
    nmi_pend_nxt = (nmi_pend_r & ~nmi_clr) | nmi_evt;
  end

  // Fold sources into vectors, and NMI flags into the NMI request
  always_comb begin
    vec_pend_nxt = '0;
    for (int s = 0; s < NSRC; s++) begin
      if (src_pend_nxt[s]) begin
        vec_pend_nxt[SRC_VEC[s]] = 1'b1;
      end
    end
    nmi_req_nxt = |nmi_pend_nxt;
  end

  // Priority pick; strict compare keeps the lowest vector on a tie
  always_comb begin
    irq_nxt = '0;
    for (int v = 0; v < NVEC; v++) begin
      if (vec_pend_nxt[v] && vec_cfg[v].en &&
          (!irq_nxt.req || vec_cfg[v].prio > irq_nxt.lvl)) begin
        irq_nxt.req = 1'b1;
        irq_nxt.vec = VEC_W'(v);
        irq_nxt.lvl = vec_cfg[v].prio;
      end
    end
  end

  // State registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      src_pend_r <= '0;
      nmi_pend_r <= '0;
      vec_pend_r <= '0;
      nmi_req_r  <= 1'b0;
      irq_r      <= '0;
    end else begin
      src_pend_r <= src_pend_nxt;
      nmi_pend_r <= nmi_pend_nxt;
      vec_pend_r <= vec_pend_nxt;
      nmi_req_r  <= nmi_req_nxt;
      irq_r      <= irq_nxt;
    end
  end

  // Checking helpers: config as seen when irq_r was formed.
  // The pick uses next-state flags and live config, so the checks
  // must compare against the config that was sampled on that edge.
  vih_vcfg_t [NVEC-1:0] cfg_seen_r;
  logic [NSRC-1:0]      clr_only;
  logic [NNMI-1:0]      nmi_clr_only;
  logic [NVEC-1:0]      en_seen;
  logic [NVEC-1:0]      vec_fold;
  logic                 outranked;

  always_ff @(posedge ref_clk) begin
    cfg_seen_r <= vec_cfg;
  end

  // Rank, mask and refold helpers for the checks below
  always_comb begin
    clr_only     = src_clr & ~src_req;
    nmi_clr_only = nmi_clr & ~nmi_evt;
    en_seen      = '0;
    vec_fold     = '0;
    outranked    = 1'b0;
    // Refold from registered flags, apart from the next-state path
    for (int s = 0; s < NSRC; s++) begin
      if (src_pend_r[s]) begin
        vec_fold[SRC_VEC[s]] = 1'b1;
      end
    end
    for (int v = 0; v < NVEC; v++) begin
      en_seen[v] = cfg_seen_r[v].en;
      if (vec_pend_r[v] && cfg_seen_r[v].en &&
          (cfg_seen_r[v].prio > irq_r.lvl ||
           (cfg_seen_r[v].prio == irq_r.lvl && VEC_W'(v) < irq_r.vec))) begin
        outranked = 1'b1;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_src_set_wins: assert property (
    (src_req != '0) |=> ((src_pend_r & $past(src_req)) == $past(src_req)))
    else $error("source event lost");

  a_src_clear: assert property (
    (clr_only != '0) |=> ((src_pend_r & $past(clr_only)) == '0))
    else $error("source flag not cleared");

  a_src_hold: assert property (
    (src_pend_r != '0 && src_clr == '0) |=>
      ((src_pend_r & $past(src_pend_r)) == $past(src_pend_r)))
    else $error("source flag dropped without clear");

  a_nmi_raise: assert property (
    (nmi_evt != '0) |=> nmi_pend_r != '0 && nmi_req_r)
    else $error("NMI not raised");

  a_nmi_quiet: assert property (
    (nmi_pend_r == '0) |-> !nmi_req_r)
    else $error("NMI without pending source");

  a_shared_ext2: assert property (
    src_req[SRC_EXT2] |=> vec_pend_r[VEC_SHARED_EXT2])
    else $error("ext2 not on shared vector");

  a_irq_valid: assert property (
    irq_r.req |-> vec_pend_r[irq_r.vec] && cfg_seen_r[irq_r.vec].en &&
                  irq_r.lvl == cfg_seen_r[irq_r.vec].prio)
    else $error("presented vector not pending or masked");

  a_irq_best: assert property (
    irq_r.req |-> !outranked)
    else $error("higher ranked vector passed over");

  a_irq_idle: assert property (
    !irq_r.req |-> !outranked && (vec_pend_r & en_seen) == '0)
    else $error("pending enabled vector not presented");

  // NMI flags follow the same set-wins rule as the maskable ones
  a_nmi_set_wins: assert property (
    (nmi_evt != '0) |=> ((nmi_pend_r & $past(nmi_evt)) == $past(nmi_evt)))
    else $error("NMI event lost");

  a_nmi_clear: assert property (
    (nmi_clr_only != '0) |=> ((nmi_pend_r & $past(nmi_clr_only)) == '0))
    else $error("NMI flag not cleared");

  a_nmi_hold: assert property (
    (nmi_pend_r != '0 && nmi_clr == '0) |=>
      ((nmi_pend_r & $past(nmi_pend_r)) == $past(nmi_pend_r)))
    else $error("NMI flag dropped without clear");

  // Vector flags must always match a fold of the source flags
  a_vec_fold: assert property (
    vec_pend_r == vec_fold)
    else $error("vector flags disagree with source flags");

  // A lone ext0 request lights exactly its own vector
  a_ext_dedicated: assert property (
    (src_pend_r == '0 && src_req == (NSRC'(1) << SRC_EXT0)) |=>
      ($onehot(vec_pend_r) && vec_pend_r[SRC_VEC[SRC_EXT0]]))
    else $error("ext0 vector not dedicated");

  a_xevt_vector: assert property (
    (src_pend_r == '0 && src_req == (NSRC'(1) << SRC_XEVT)) |=>
      ($onehot(vec_pend_r) && vec_pend_r[SRC_VEC[SRC_XEVT]]))
    else $error("extended group vector not dedicated");

  // Reset must clear everything the core can see, one edge later
  a_reset_clear: assert property (
    @(posedge ref_clk) disable iff (1'b0)
    (!rst_n) |=> (src_pend_r == '0 && nmi_pend_r == '0 &&
                  vec_pend_r == '0 && !nmi_req_r && irq_r == '0))
    else $error("outputs not cleared by reset");

  c_nmi_and_irq: cover property (nmi_req_r && irq_r.req);
  c_shared_three: cover property (
    src_pend_r[SRC_GTB] && src_pend_r[SRC_MULDIV] && src_pend_r[SRC_EXT2]);
  c_set_on_clear: cover property ((src_req & src_clr) != '0);
  c_top_level: cover property (irq_r.req && irq_r.lvl == LVL_W'(NLVL - 1));
  // Masked vectors keep their flags but stay hidden from the core
  c_masked_pending: cover property (vec_pend_r != '0 && !irq_r.req);

endmodule : vih_hub

`default_nettype wire

// >>> sim/vih_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// Handler stand-in: clears every source of the presented vector
module vih_core_model
  import vih_pkg::*;
(
  input  wire logic            ref_clk,
  input  wire logic            serve,
  input  wire vih_irq_t        irq_r,
  output var  logic [NSRC-1:0] clr
);
  // One pulse, then a gap so the flags settle before the next pick
  always @(posedge ref_clk) begin
    clr <= '0;
    if (serve && irq_r.req && clr == '0)
      for (int i = 0; i < NSRC; i++)
        clr[i] <= (SRC_VEC[i] == irq_r.vec);
  end
endmodule : vih_core_model
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
  import vih_pkg::*;
;
  typedef struct packed {
    logic [NSRC-1:0] s;
    logic [NNMI-1:0] n;
    logic [NVEC-1:0] v;
    vih_irq_t        q;
  } vih_exp_t;
  logic                 ref_clk, rst_n, serve, probe, probe_d;
  logic [NSRC-1:0]      src_req, tb_clr, mclr, src_pend_r, cur_s;
  logic [NNMI-1:0]      nmi_evt, nmi_clr, nmi_pend_r, cur_n;
  vih_vcfg_t [NVEC-1:0] vec_cfg;
  logic [NVEC-1:0]      vec_pend_r;
  logic                 nmi_req_r;
  vih_irq_t             irq_r;
  vih_exp_t             e;
  vih_exp_t             expq[$];
  int                   fail_count, n_tests, cyc;

  vih_hub dut (.ref_clk(ref_clk), .rst_n(rst_n), .src_req(src_req),
    .src_clr(tb_clr | mclr), .nmi_evt(nmi_evt), .nmi_clr(nmi_clr),
    .vec_cfg(vec_cfg), .src_pend_r(src_pend_r), .nmi_pend_r(nmi_pend_r),
    .vec_pend_r(vec_pend_r), .nmi_req_r(nmi_req_r), .irq_r(irq_r));
  vih_core_model core (.ref_clk(ref_clk), .serve(serve), .irq_r(irq_r),
    .clr(mclr));

  // Reference: descending scan with >= so ties fall to the lowest vector
  function automatic vih_exp_t model(logic [NSRC-1:0] s,
                                     logic [NNMI-1:0] n);
    vih_exp_t x;
    x = '0;
    x.s = s;
    x.n = n;
    for (int i = 0; i < NSRC; i++)
      if (s[i]) x.v[SRC_VEC[i]] = 1'b1;
    for (int j = NVEC - 1; j >= 0; j--)
      if (x.v[j] && vec_cfg[j].en && (!x.q.req || vec_cfg[j].prio >= x.q.lvl))
        x.q = {1'b1, VEC_W'(j), vec_cfg[j].prio};
    return x;
  endfunction : model

  task automatic check(logic [63:0] seen, logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  // One event cycle; set beats a coincident clear in the reference
  task automatic ev(logic [NSRC-1:0] r, logic [NSRC-1:0] c,
                    logic [NNMI-1:0] nr, logic [NNMI-1:0] nc);
    @(posedge ref_clk) #1;
    {src_req, tb_clr, nmi_evt, nmi_clr, probe} = {r, c, nr, nc, 1'b1};
    cur_s = (cur_s & ~c) | r;
    cur_n = (cur_n & ~nc) | nr;
    expq.push_back(model(cur_s, cur_n));
    @(posedge ref_clk) #1;
    {src_req, tb_clr, nmi_evt, nmi_clr, probe} = '0;
  endtask : ev

  initial begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Monitor: result lands one edge after the event, checked mid-cycle
  always @(posedge ref_clk) probe_d <= probe;
  always @(negedge ref_clk) if (probe_d === 1'b1) begin
    e = expq.pop_front();
    check(64'(src_pend_r), 64'(e.s));
    check(64'(vec_pend_r), 64'(e.v));
    check(64'(irq_r), 64'(e.q));
    check(64'(nmi_pend_r), 64'(e.n));
    check(64'(nmi_req_r), 64'(|e.n));
  end

  // Hang guard, far above the ~225 cycles the run needs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial begin
    {rst_n, serve, probe, src_req, tb_clr, nmi_evt, nmi_clr} = '0;
    {cur_s, cur_n} = '0;
    void'($urandom(32'h601d));
    foreach (vec_cfg[j]) vec_cfg[j] = {1'b1, 2'($urandom)};
    repeat (5) @(posedge ref_clk);
    #1 rst_n = 1;
    // Every source alone: routing, then clear
    for (int i = 0; i < NSRC; i++) begin
      ev(NSRC'(1) << i, '0, '0, '0);
      ev('0, NSRC'(1) << i, '0, '0);
    end
    // Every NMI event alone
    for (int i = 0; i < NNMI; i++) begin
      ev('0, '0, NNMI'(1) << i, '0);
      ev('0, '0, '0, NNMI'(1) << i);
    end
    // Random mixes of events, clears, levels and disabled vectors
    repeat (40) begin
      foreach (vec_cfg[j]) vec_cfg[j] = 3'($urandom);
      ev(NSRC'($urandom), NSRC'($urandom), NNMI'($urandom),
         NNMI'($urandom));
    end
    // Core model drains every source flag, best vector first
    foreach (vec_cfg[j]) vec_cfg[j].en = 1'b1;
    ev('1, '0, '0, '0);
    serve = 1;
    for (int k = 0; k < 60 && src_pend_r !== '0; k++) @(posedge ref_clk);
    #1 check(64'(src_pend_r), 64'(0));
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
